// file: bench/tlb_page_size_grain_control_tb.sv
`default_nettype none

module tlb_page_size_grain_control_tb;
  import tlbpg_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  // ==========================================================================
  // Signals and design instances
  // ==========================================================================
  logic        sys_clk, rst, reg_wr, reg_rd, reg_sel, tlb_wr, ri_fault, xi_fault, mc_hit;
  logic [31:0] reg_wdata;
  logic [17:0] va_a, va_b;
  wire  logic [31:0] rdata [2];
  wire  logic [15:0] tmask [2];
  wire  logic [1:0]  tmaskx [2];
  wire  logic [4:0]  ecode [2];
  wire  logic [3:0]  lvl [2];
  wire  logic        rvalid [2];
  wire  logic        twout [2];
  wire  logic        evalid [2];
  wire  logic        hit [2];
  int          num_errors, cmp_count;
  logic [15:0] m [2];
  logic [31:0] g [2];
  logic [1:0]  mx;
  logic [4:0]  mcc;

  for (genvar i = 0; i < 2; i++) begin : g_dut
    tlbpg_top #(.P_REL6(i == 1), .P_MIN_SIZE(i), .P_MAX_SIZE(6)) i_dut (
      .sys_clk(sys_clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_sel(reg_sel), .reg_wdata(reg_wdata), .reg_rdata(rdata[i]),
      .reg_rvalid(rvalid[i]), .tlb_wr(tlb_wr), .tlb_wr_out(twout[i]),
      .tlb_mask(tmask[i]), .tlb_size_mask_ext_field(tmaskx[i]), .ri_wr_en(lvl[i][3]),
      .xi_wr_en(lvl[i][2]), .page_frame_number_ext_wr_en(lvl[i][1]), .small_page_en(lvl[i][0]),
      .ri_fault(ri_fault), .xi_fault(xi_fault), .exc_valid(evalid[i]),
      .exc_code(ecode[i]), .mc_multi_hit(mc_hit));
    tlbpg_tlb_model i_tlb (
      .sys_clk(sys_clk), .rst(rst), .tlb_wr_out(twout[i]), .tlb_mask(tmask[i]),
      .tlb_size_mask_ext_field(tmaskx[i]), .va_a(va_a), .va_b(va_b), .hit(hit[i]));
  end

  always #5 sys_clk = ~sys_clk;

  // ==========================================================================
  // Expectations and bus tasks
  // ==========================================================================
  function automatic logic [15:0] enc(input int k);
    return (16'h0001 << (2 * k)) - 16'h0001;
  endfunction

  function automatic logic ok6(input logic [15:0] v);
    ok6 = (v == MASK_ALL_ONES);
    for (int k = 1; k < 7; k++) begin
      ok6 |= (v == enc(k));
    end
  endfunction

  function automatic logic [31:0] exp_rd(input int i, input logic s);
    logic [1:0] x;
    x = (i == 0 && g[0][28]) ? mx : 2'h0;
    return s ? (g[i] | {27'h0, mcc}) : {3'h0, m[i], x, 11'h000};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic give_verdict();
    $display("errors %0d comparisons %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic wr(input logic s, input logic [31:0] d);
    logic [15:0] v;
    v = d[28:13];
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_sel <= s;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    if (s == SEL_PAGE_GRAIN) begin
      g[0] = d & 32'hF8000000;
      g[1] = 32'hC0000000 | (d & 32'h28000000);
    end else begin
      m[0] = v & enc(6);
      mx = g[0][28] ? d[12:11] : mx;
      m[1] = (v == MASK_ALL_ONES) ? enc(6) : (ok6(v) ? v : m[1]);
    end
  endtask

  task automatic rd(input logic s);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_sel <= s;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    for (int i = 0; i < 2; i++) begin
      chk(rvalid[i], 1'b1, "read valid");
      chk(rdata[i], exp_rd(i, s), "read data");
      if (s) chk(lvl[i], g[i][31:28], "enable levels");
    end
  endtask

  task automatic tw();
    logic [1:0]  xe;
    logic [17:0] a, d;
    xe = g[0][28] ? mx : SIZE_MASK_EXT_FIELD_FORCED;
    a = 18'($urandom);
    d = 18'($urandom) & (($urandom_range(1, 0) == 1) ? {m[1], 2'h0} : 18'h3FFFF);
    @(posedge sys_clk);
    tlb_wr <= 1'b1;
    @(posedge sys_clk);
    tlb_wr <= 1'b0;
    va_a <= a;
    va_b <= a ^ d;
    #1;
    for (int i = 0; i < 2; i++) begin
      chk(twout[i], 1'b1, "entry write pulse");
      chk(tmask[i], m[i], "entry mask");
      chk(tmaskx[i], i ? SIZE_MASK_EXT_FIELD_FORCED : xe, "entry ext mask");
    end
    @(posedge sys_clk);
    #1;
    chk(hit[0], (d & ~{m[0], xe}) == 18'h0, "match even");
    chk(hit[1], (d & ~{m[1], 2'h3}) == 18'h0, "match odd");
  endtask

  task automatic flt(input logic r);
    @(posedge sys_clk);
    ri_fault <= r;
    xi_fault <= ~r;
    @(posedge sys_clk);
    ri_fault <= 1'b0;
    xi_fault <= 1'b0;
    #1;
    for (int i = 0; i < 2; i++) begin
      chk(evalid[i], 1'b1, "fault pulse");
      chk(ecode[i], g[i][27] ? (r ? 5'h13 : 5'h14) : 5'h02, "fault code");
    end
  endtask

  // ==========================================================================
  // Watchdog and main sequence
  // ==========================================================================
  initial begin
    repeat (20000) @(posedge sys_clk);
    num_errors++;
    give_verdict();
  end

  initial begin
    {sys_clk, reg_wr, reg_rd, reg_sel, tlb_wr, ri_fault, xi_fault, mc_hit} = 8'h00;
    rst = 1'b1;
    reg_wdata = 32'h00000000;
    {va_a, va_b} = 36'h0;
    {num_errors, cmp_count} = 64'h0;
    g[0] = 32'h00000000;
    g[1] = 32'hC8000000;
    mx = 2'h0;
    mcc = MCC_NONE;
    void'($urandom(89));
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    rd(SEL_PAGE_GRAIN);
    flt(1'b1);
    flt(1'b0);
    wr(SEL_PAGE_MASK, {3'h0, enc(1), SIZE_MASK_EXT_FIELD_FORCED, 11'h000});
    wr(SEL_PAGE_MASK, {3'h0, MASK_ALL_ONES, SIZE_MASK_EXT_FIELD_FORCED, 11'h000});
    rd(SEL_PAGE_MASK);
    for (int n = 0; n < 24; n++) begin
      wr(SEL_PAGE_MASK, {3'h0, enc($urandom_range(8, 0)), SIZE_MASK_EXT_FIELD_FORCED, 11'h000});
      rd(SEL_PAGE_MASK);
      tw();
      if ($urandom_range(2, 0) == 0) begin
        wr(SEL_PAGE_GRAIN, $urandom & 32'hE800001F);
        rd(SEL_PAGE_GRAIN);
        flt(1'($urandom_range(1, 0)));
      end
    end
    wr(SEL_PAGE_GRAIN, 32'h10000000);
    wr(SEL_PAGE_MASK, {3'h0, enc(2), 2'h1, 11'h000});
    rd(SEL_PAGE_MASK);
    tw();
    wr(SEL_PAGE_MASK, {3'h0, enc(2), SIZE_MASK_EXT_FIELD_FORCED, 11'h000});
    wr(SEL_PAGE_GRAIN, 32'h00000000);
    rd(SEL_PAGE_MASK);
    tw();
    rd(SEL_PAGE_GRAIN);
    @(posedge sys_clk);
    mc_hit <= 1'b1;
    @(posedge sys_clk);
    mc_hit <= 1'b0;
    mcc = MCC_MULTI_HIT;
    rd(SEL_PAGE_GRAIN);
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    g[0] = 32'h00000000;
    g[1] = 32'hC8000000;
    mcc = MCC_NONE;
    rd(SEL_PAGE_GRAIN);
    give_verdict();
  end
endmodule // tlb_page_size_grain_control_tb

`default_nettype wire

// file: bench/tlbpg_tlb_model.sv
`default_nettype none

module tlbpg_tlb_model (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        tlb_wr_out,
  input  wire logic [15:0] tlb_mask,
  input  wire logic [1:0]  tlb_size_mask_ext_field,
  input  wire logic [17:0] va_a,
  input  wire logic [17:0] va_b,
  output logic             hit
);
  timeunit 1ns;
  timeprecision 1ns;

  // ==========================================================================
  // Single TLB entry
  // ==========================================================================
  logic [17:0] ent_ign_r;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ent_ign_r <= 18'h00000;
    end else if (tlb_wr_out) begin
      ent_ign_r <= {tlb_mask, tlb_size_mask_ext_field};
    end
  end

  assign hit = ((va_a ^ va_b) & ~ent_ign_r) == 18'h00000;
endmodule // tlbpg_tlb_model

`default_nettype wire

// file: rtl/tlbpg_mask_chk.sv
`default_nettype none

module tlbpg_mask_chk
  import tlbpg_pkg::*;
#(
  parameter bit          P_REL6     = 1'b0,
  parameter int unsigned P_MIN_SIZE = 0,
  parameter int unsigned P_MAX_SIZE = 8
) (
  tlbpg_mask_if.chk m
);

  logic [NUM_SIZES-1:0] hit;
  logic                 all_ones;
  logic                 legal;

  // ==========================================================================
  // Per bit pair support and per size legal encodings
  // ==========================================================================
  genvar g;
  generate
    for (g = 0; g < NUM_SIZES; g = g + 1) begin : g_size
      localparam logic [31:0] ENC = (32'h1 << (2 * g)) - 32'h1;
      if (g < NUM_PAIRS) begin : g_pair
        // A pair is implemented when its size is not above the largest one.
        assign m.sup_bits[2*g+1:2*g] = (g + 1 <= P_MAX_SIZE) ? 2'h3 : 2'h0;
        assign m.ro_bits[2*g+1:2*g]  = (P_REL6 && (g + 1 <= P_MIN_SIZE)) ? 2'h3 : 2'h0;
      end
      assign hit[g] = (g >= P_MIN_SIZE) && (g <= P_MAX_SIZE) && (m.wmask == ENC[15:0]);
    end
  endgenerate

  assign all_ones = (m.wmask == MASK_ALL_ONES);
  assign legal    = |hit;

  // ==========================================================================
  // Write acceptance and read view
  // ==========================================================================
  always_comb begin
    if (P_REL6) begin
      m.wr_accept = legal || all_ones;
      if (legal) begin
        m.wr_next = m.wmask;
      end else if (all_ones) begin
        m.wr_next = m.sup_bits | m.ro_bits;
      end else begin
        m.wr_next = m.cur;
      end
    end else begin
      m.wr_accept = 1'b1;
      m.wr_next   = m.wmask & m.sup_bits;
    end
  end

  assign m.rd_view = (m.cur & m.sup_bits) | m.ro_bits;

endmodule // tlbpg_mask_chk

`default_nettype wire

// file: rtl/tlbpg_mask_if.sv
`default_nettype none

interface tlbpg_mask_if;
  logic [15:0] wmask;
  logic [15:0] cur;
  logic [15:0] wr_next;
  logic [15:0] rd_view;
  logic [15:0] sup_bits;
  logic [15:0] ro_bits;
  logic        wr_accept;

  modport chk (
    input  wmask,
    input  cur,
    output wr_next,
    output rd_view,
    output sup_bits,
    output ro_bits,
    output wr_accept
  );

  modport user (
    output wmask,
    output cur,
    input  wr_next,
    input  rd_view,
    input  sup_bits,
    input  ro_bits,
    input  wr_accept
  );
endinterface : tlbpg_mask_if

`default_nettype wire

// file: rtl/tlbpg_pkg.sv
`default_nettype none

package tlbpg_pkg;

  // ==========================================================================
  // Register select codes
  // ==========================================================================
  localparam logic SEL_PAGE_MASK  = 1'b0;
  localparam logic SEL_PAGE_GRAIN = 1'b1;

  // ==========================================================================
  // Page size mask register layout
  // ==========================================================================
  localparam int unsigned MASK_W     = 16;
  localparam int unsigned MASK_LSB   = 13;
  localparam int unsigned MASK_MSB   = 28;
  localparam int unsigned SIZE_MASK_EXT_FIELD_LSB  = 11;
  localparam int unsigned SIZE_MASK_EXT_FIELD_MSB  = 12;
  localparam int unsigned NUM_PAIRS  = 8;
  localparam int unsigned NUM_SIZES  = 9;

  localparam logic [15:0] MASK_ENC_1MB   = 16'h00FF;
  localparam logic [15:0] MASK_ENC_4MB   = 16'h03FF;
  localparam logic [15:0] MASK_ENC_16MB  = 16'h0FFF;
  localparam logic [15:0] MASK_ENC_64MB  = 16'h3FFF;
  localparam logic [15:0] MASK_ENC_256MB = 16'hFFFF;
  localparam logic [15:0] MASK_ALL_ONES  = 16'hFFFF;
  localparam logic [15:0] MASK_ZERO      = 16'h0000;
  localparam logic [1:0]  SIZE_MASK_EXT_FIELD_FORCED   = 2'h3;
  localparam logic [1:0]  SIZE_MASK_EXT_FIELD_ZERO     = 2'h0;

  // ==========================================================================
  // Page granularity control layout
  // ==========================================================================
  localparam int unsigned RIE_BIT  = 31;
  localparam int unsigned XIE_BIT  = 30;
  localparam int unsigned LARGE_PHYS_ADDR_ENABLE_BIT = 29;
  localparam int unsigned ESP_BIT  = 28;
  localparam int unsigned IEC_BIT  = 27;
  localparam int unsigned ASE_LSB  = 8;
  localparam int unsigned ASE_MSB  = 12;
  localparam int unsigned MCC_LSB  = 0;
  localparam int unsigned MCC_MSB  = 4;
  localparam int unsigned RSV_HI_LSB = 13;
  localparam int unsigned RSV_HI_MSB = 25;
  localparam int unsigned RSV_LO_LSB = 5;
  localparam int unsigned RSV_LO_MSB = 7;

  localparam logic [4:0]  MCC_NONE      = 5'h00;
  localparam logic [4:0]  MCC_MULTI_HIT = 5'h01;
  localparam logic [4:0]  ASE_ZERO      = 5'h00;
  localparam logic [31:0] WORD_ZERO     = 32'h00000000;

endpackage : tlbpg_pkg

`default_nettype wire

// file: rtl/tlbpg_top.sv
`default_nettype none

module tlbpg_top #(
  parameter bit          P_REL6      = 1'b0,
  parameter bit          P_SP        = 1'b1,
  parameter bit          P_LPA       = 1'b1,
  parameter bit          P_RXI       = 1'b1,
  parameter bit          P_ASE       = 1'b0,
  parameter int unsigned P_MIN_SIZE  = 0,
  parameter int unsigned P_MAX_SIZE  = 8,
  parameter logic [4:0]  P_EXC_TLB_LOAD_EXC_CODE  = 5'h02,
  parameter logic [4:0]  P_EXC_RI    = 5'h13,
  parameter logic [4:0]  P_EXC_XI    = 5'h14
) (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic        reg_sel,
  input  wire logic [31:0] reg_wdata,
  output logic [31:0]      reg_rdata,
  output logic             reg_rvalid,
  input  wire logic        tlb_wr,
  output logic             tlb_wr_out,
  output logic [15:0]      tlb_mask,
  output logic [1:0]       tlb_size_mask_ext_field,
  output logic             ri_wr_en,
  output logic             xi_wr_en,
  output logic             page_frame_number_ext_wr_en,
  output logic             small_page_en,
  input  wire logic        ri_fault,
  input  wire logic        xi_fault,
  output logic             exc_valid,
  output logic [4:0]       exc_code,
  input  wire logic        mc_multi_hit
);
  import tlbpg_pkg::*;

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    logic [15:0] mask;
    logic [1:0]  size_mask_ext_field;
    logic        read_inhibit_enable;
    logic        exec_inhibit_enable;
    logic        large_phys_addr_enable;
    logic        small_page_enable;
    logic        iec;
    logic [4:0]  extension_reserved_field;
    logic [4:0]  mcc;
    logic [31:0] rdata;
    logic        rvalid;
    logic        tlb_wr;
    logic [15:0] tlb_mask;
    logic [1:0]  tlb_size_mask_ext_field;
    logic        exc_valid;
    logic [4:0]  exc_code;
  } tlbpg_state_t;

  localparam logic INH_RST = P_REL6;
  localparam logic IEC_RST = P_REL6;

  localparam tlbpg_state_t ST_RST = '{
    mask:      MASK_ZERO,
    size_mask_ext_field:     SIZE_MASK_EXT_FIELD_ZERO,
    read_inhibit_enable:       INH_RST,
    exec_inhibit_enable:       INH_RST,
    large_phys_addr_enable:      1'b0,
    small_page_enable:       1'b0,
    iec:       IEC_RST,
    extension_reserved_field:       ASE_ZERO,
    mcc:       MCC_NONE,
    rdata:     WORD_ZERO,
    rvalid:    1'b0,
    tlb_wr:    1'b0,
    tlb_mask:  MASK_ZERO,
    tlb_size_mask_ext_field: SIZE_MASK_EXT_FIELD_FORCED,
    exc_valid: 1'b0,
    exc_code:  5'h00
  };

  tlbpg_state_t s_r;
  tlbpg_state_t s_nxt;
  logic [31:0]  mask_word;
  logic [31:0]  grain_word;
  logic         wr_mask;
  logic         wr_grain;

  tlbpg_mask_if mif ();

  tlbpg_mask_chk #(
    .P_REL6     (P_REL6),
    .P_MIN_SIZE (P_MIN_SIZE),
    .P_MAX_SIZE (P_MAX_SIZE)
  ) u_chk (
    .m (mif.chk)
  );

  assign mif.wmask = reg_wdata[MASK_MSB:MASK_LSB];
  assign mif.cur   = s_r.mask;
  assign wr_mask   = reg_wr && (reg_sel == SEL_PAGE_MASK);
  assign wr_grain  = reg_wr && (reg_sel == SEL_PAGE_GRAIN);

  // ==========================================================================
  // Read views
  // ==========================================================================
  always_comb begin
    mask_word = WORD_ZERO;
    mask_word[MASK_MSB:MASK_LSB] = mif.rd_view;
    mask_word[SIZE_MASK_EXT_FIELD_MSB:SIZE_MASK_EXT_FIELD_LSB] = s_r.small_page_enable ? s_r.size_mask_ext_field : SIZE_MASK_EXT_FIELD_ZERO;
    grain_word = WORD_ZERO;
    grain_word[RIE_BIT]  = s_r.read_inhibit_enable;
    grain_word[XIE_BIT]  = s_r.exec_inhibit_enable;
    grain_word[LARGE_PHYS_ADDR_ENABLE_BIT] = s_r.large_phys_addr_enable;
    grain_word[ESP_BIT]  = s_r.small_page_enable;
    grain_word[IEC_BIT]  = s_r.iec;
    grain_word[ASE_MSB:ASE_LSB] = P_ASE ? s_r.extension_reserved_field : ASE_ZERO;
    grain_word[MCC_MSB:MCC_LSB] = s_r.mcc;
  end

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    s_nxt           = s_r;
    s_nxt.rvalid    = 1'b0;
    s_nxt.tlb_wr    = 1'b0;
    s_nxt.exc_valid = 1'b0;

    if (reg_rd) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata  = (reg_sel == SEL_PAGE_MASK) ? mask_word : grain_word;
    end

    if (wr_mask) begin
      s_nxt.mask = mif.wr_next;
      if (s_r.small_page_enable) begin
        s_nxt.size_mask_ext_field = reg_wdata[SIZE_MASK_EXT_FIELD_MSB:SIZE_MASK_EXT_FIELD_LSB];
      end
    end

    if (wr_grain) begin
      if (!P_REL6 && P_RXI) begin
        s_nxt.read_inhibit_enable = reg_wdata[RIE_BIT];
        s_nxt.exec_inhibit_enable = reg_wdata[XIE_BIT];
      end
      if (P_LPA) begin
        s_nxt.large_phys_addr_enable = reg_wdata[LARGE_PHYS_ADDR_ENABLE_BIT];
      end
      if (P_SP && !P_REL6) begin
        s_nxt.small_page_enable = reg_wdata[ESP_BIT];
      end
      s_nxt.iec = reg_wdata[IEC_BIT];
      if (P_ASE) begin
        s_nxt.extension_reserved_field = reg_wdata[ASE_MSB:ASE_LSB];
      end
    end

    if (tlb_wr) begin
      s_nxt.tlb_wr    = 1'b1;
      s_nxt.tlb_mask  = mif.rd_view;
      s_nxt.tlb_size_mask_ext_field = s_r.small_page_enable ? s_r.size_mask_ext_field : SIZE_MASK_EXT_FIELD_FORCED;
    end

    if (ri_fault) begin
      s_nxt.exc_valid = 1'b1;
      s_nxt.exc_code  = s_r.iec ? P_EXC_RI : P_EXC_TLB_LOAD_EXC_CODE;
    end else if (xi_fault) begin
      s_nxt.exc_valid = 1'b1;
      s_nxt.exc_code  = s_r.iec ? P_EXC_XI : P_EXC_TLB_LOAD_EXC_CODE;
    end

    if (mc_multi_hit) begin
      s_nxt.mcc = MCC_MULTI_HIT;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_r <= ST_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign reg_rdata     = s_r.rdata;
  assign reg_rvalid    = s_r.rvalid;
  assign tlb_wr_out    = s_r.tlb_wr;
  assign tlb_mask      = s_r.tlb_mask;
  assign tlb_size_mask_ext_field     = s_r.tlb_size_mask_ext_field;
  assign ri_wr_en      = s_r.read_inhibit_enable;
  assign xi_wr_en      = s_r.exec_inhibit_enable;
  assign page_frame_number_ext_wr_en    = s_r.large_phys_addr_enable;
  assign small_page_en = s_r.small_page_enable;
  assign exc_valid     = s_r.exc_valid;
  assign exc_code      = s_r.exc_code;

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  sequence seq_wr_mask(logic [15:0] v);
    wr_mask && !reg_rd && (mif.wmask == v);
  endsequence

  sequence seq_rd_mask;
    reg_rd && (reg_sel == SEL_PAGE_MASK) && !reg_wr && !tlb_wr;
  endsequence

  AST_MASK_1MB: assert property (
    (seq_wr_mask(MASK_ENC_1MB) and (P_MAX_SIZE >= 4) and (P_MIN_SIZE <= 4))
      |=> (s_r.mask == MASK_ENC_1MB)
  ) else $error("1 MB mask encoding not stored");

  AST_SIZE_MASK_EXT_FIELD_TLB: assert property (
    (tlb_wr && !s_r.small_page_enable) |=> (tlb_wr_out && (tlb_size_mask_ext_field == SIZE_MASK_EXT_FIELD_FORCED))
  ) else $error("entry extension mask not forced to ones");

  AST_SIZE_MASK_EXT_FIELD_RD: assert property (
    (reg_rd && (reg_sel == SEL_PAGE_MASK) && !s_r.small_page_enable)
      |=> (reg_rvalid && (reg_rdata[SIZE_MASK_EXT_FIELD_MSB:SIZE_MASK_EXT_FIELD_LSB] == SIZE_MASK_EXT_FIELD_ZERO))
  ) else $error("extension mask readable while disabled");

  AST_UNSUP_ZERO: assert property (
    (!P_REL6 && reg_rd && (reg_sel == SEL_PAGE_MASK))
      |=> ((reg_rdata[MASK_MSB:MASK_LSB] & ~$past(mif.sup_bits)) == MASK_ZERO)
  ) else $error("unimplemented size bits read as ones");

  AST_RO_ONES: assert property (
    (reg_rd && (reg_sel == SEL_PAGE_MASK))
      |=> ((reg_rdata[MASK_MSB:MASK_LSB] & $past(mif.ro_bits)) == $past(mif.ro_bits))
  ) else $error("fixed ones not read back");

  AST_4KB: assert property (
    ((!P_REL6 && !tlb_wr) and seq_wr_mask(MASK_ZERO)) ##1 !reg_wr ##1 seq_rd_mask
      |=> (reg_rdata[MASK_MSB:MASK_LSB] == MASK_ZERO)
  ) else $error("4 kB size not supported");

  AST_IGNORE_BAD: assert property (
    (P_REL6 && wr_mask && !mif.wr_accept) |=> $stable(s_r.mask)
  ) else $error("illegal mask write changed the field");

  AST_DISCOVER: assert property (
    seq_wr_mask(MASK_ALL_ONES) ##1 !reg_wr ##1 seq_rd_mask
      |=> (reg_rdata[MASK_MSB:MASK_LSB] == $past(mif.sup_bits | mif.ro_bits))
  ) else $error("all-ones readback does not show implemented sizes");

  AST_RIE_SET: assert property (
    (wr_grain && reg_wdata[RIE_BIT] && !P_REL6 && P_RXI) |=> ri_wr_en
  ) else $error("read inhibit enable did not set");

  AST_LARGE_PHYS_ADDR_ENABLE_NOSUP: assert property (
    !P_LPA |-> !page_frame_number_ext_wr_en
  ) else $error("frame extension enabled without support");

  AST_ESP_NOSUP: assert property (
    (!P_SP || P_REL6) |-> (!small_page_en && (grain_word[ESP_BIT] == 1'b0))
  ) else $error("small page enable set without support");

  AST_EXC_CODE: assert property (
    (ri_fault && !s_r.iec) |=> (exc_valid && (exc_code == P_EXC_TLB_LOAD_EXC_CODE))[*1] ##0
      (exc_code == $past(s_r.iec ? P_EXC_RI : P_EXC_TLB_LOAD_EXC_CODE))
  ) else $error("wrong inhibit exception code");

  AST_RSVD: assert property (
    (reg_rd && (reg_sel == SEL_PAGE_GRAIN))
      |=> ((reg_rdata[RSV_HI_MSB:RSV_HI_LSB] == 13'h0000)
           && (reg_rdata[RSV_LO_MSB:RSV_LO_LSB] == 3'h0))
  ) else $error("reserved bits read nonzero");

  AST_MC_HIT: assert property (
    mc_multi_hit ##[1:4] (reg_rd && (reg_sel == SEL_PAGE_GRAIN))
      |=> (reg_rdata[MCC_MSB:MCC_LSB] == MCC_MULTI_HIT)
  ) else $error("multiple hit cause not reported");

endmodule // tlbpg_top

`default_nettype wire
